// ==== core/uart_codec_defines.svh ====
`ifndef UART_CODEC_DEFINES_SVH
`define UART_CODEC_DEFINES_SVH
`define ADDR_MATCH_OFS 12'hf45
`define DIV_HIGH_OFS 12'hf46
`define DIV_LOW_OFS 12'hf47
`define CTRL_OFS 12'hf48
`define STATUS_OFS 12'hf49
`define ADDR_MATCH_RST 8'h00
`define DIV_HIGH_RST 8'hff
`define DIV_LOW_RST 8'hff
`define CTRL_RST 8'h00
`define CTRL_IR_EN_BIT 0
`define SAMPLES_PER_BIT 16
`define IR_WINDOW_HALF 8
`endif

// ==== core/uart_codec_pkg.sv ====
package uart_codec_pkg;
  typedef enum logic [1:0] {IR_IDLE, IR_TRACK} ir_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
  typedef logic [15:0] divisor_t;
endpackage

// ==== core/baud_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "uart_codec_defines.svh"
module baud_tick_gen
  import uart_codec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire divisor_t divisor_i,
  output logic tick_o
);
  divisor_t count_reg, count_next;
  divisor_t load_reg, load_next;
  logic tick_reg, tick_next;

  // the divisor is sampled only at reload so a tick period in progress keeps its length
  always_comb begin
    count_next = count_reg + 16'h0001;
    load_next = load_reg;
    tick_next = 1'b0;
    if (count_reg >= load_reg) begin
      count_next = 16'h0001;
      tick_next = 1'b1;
      load_next = (divisor_i == 16'h0000) ? 16'h0001 : divisor_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      count_reg <= 16'h0001;
      load_reg <= 16'hffff;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      load_reg <= load_next;
      tick_reg <= tick_next;
    end
  end
  assign tick_o = tick_reg;

  chk_tick_single: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    tick_o |=> !tick_o || load_reg == 16'h0001)
    else $error("tick repeated with divisor above one");
  chk_reload_only: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !tick_next |=> $stable(load_reg))
    else $error("divisor changed outside reload");
endmodule // baud_tick_gen
`default_nettype wire

// ==== core/uart_baud_and_infrared_codec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "uart_codec_defines.svh"
module uart_baud_and_infrared_codec
  import uart_codec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rx_pin_i,
  output logic sample_tick_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_addr_match_o,
  output logic rx_frame_err_o
);
  logic [7:0] addr_match_reg, addr_match_next;
  logic [7:0] div_high_reg, div_high_next;
  logic [7:0] div_low_reg, div_low_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  divisor_t baud_divisor;
  logic tick;
  logic infrared_codec_enable;

  assign baud_divisor = {div_high_reg, div_low_reg};
  assign infrared_codec_enable = ctrl_reg[`CTRL_IR_EN_BIT];

  baud_tick_gen u_tick (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .divisor_i(baud_divisor),
    .tick_o(tick)
  );
  assign sample_tick_o = tick;

  // ---------------- infrared decoder
  ir_state_e ir_state_reg, ir_state_next;
  logic [4:0] ir_cnt_reg, ir_cnt_next;
  logic ir_prev_reg, ir_prev_next;
  logic ir_out_reg, ir_out_next;
  logic [4:0] ir_hold_reg, ir_hold_next;
  logic ir_fall;
  logic rx_line;

  assign ir_fall = ir_prev_reg && !rx_pin_i;

  always_comb begin
    ir_state_next = ir_state_reg;
    ir_cnt_next = ir_cnt_reg;
    ir_prev_next = rx_pin_i;
    ir_out_next = ir_out_reg;
    ir_hold_next = ir_hold_reg;
    if (tick && ir_hold_reg != 5'h00) begin
      ir_hold_next = ir_hold_reg - 5'h01;
    end
    if (tick && ir_hold_reg == 5'h01) begin
      ir_out_next = 1'b1;
    end
    unique case (ir_state_reg)
      IR_IDLE: begin
        if (ir_fall) begin
          ir_state_next = IR_TRACK;
          ir_cnt_next = 5'h00;
          ir_out_next = 1'b0;
          ir_hold_next = 5'(`SAMPLES_PER_BIT);
        end
      end
      IR_TRACK: begin
        if (ir_fall) begin
          ir_cnt_next = 5'h00;
          if (ir_cnt_reg >= 5'(`SAMPLES_PER_BIT - `IR_WINDOW_HALF)) begin
            ir_out_next = 1'b0;
            ir_hold_next = 5'(`SAMPLES_PER_BIT);
          end
        end else if (tick) begin
          if (ir_cnt_reg >= 5'(`SAMPLES_PER_BIT + `IR_WINDOW_HALF)) begin
            ir_state_next = IR_IDLE;
          end else begin
            ir_cnt_next = ir_cnt_reg + 5'h01;
          end
        end
      end
      default: ir_state_next = IR_IDLE;
    endcase
    if (!infrared_codec_enable) begin
      ir_state_next = IR_IDLE;
      ir_out_next = 1'b1;
      ir_hold_next = 5'h00;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ir_state_reg <= IR_IDLE;
      ir_cnt_reg <= 5'h00;
      ir_prev_reg <= 1'b1;
      ir_out_reg <= 1'b1;
      ir_hold_reg <= 5'h00;
    end else begin
      ir_state_reg <= ir_state_next;
      ir_cnt_reg <= ir_cnt_next;
      ir_prev_reg <= ir_prev_next;
      ir_out_reg <= ir_out_next;
      ir_hold_reg <= ir_hold_next;
    end
  end

  // the receiver sees either the decoded line or the raw pin; with the codec off, decoder state never touches it
  assign rx_line = infrared_codec_enable ? ir_out_reg : rx_pin_i;

  // ---------------- serial receiver, 9 data bits, bit 8 marks an address byte
  rx_state_e rx_state_reg, rx_state_next;
  logic [3:0] rx_phase_reg, rx_phase_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [8:0] rx_shift_reg, rx_shift_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next;
  logic rx_match_reg, rx_match_next;
  logic rx_err_reg, rx_err_next;
  logic rx_line_prev_reg, rx_line_prev_next;

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_phase_next = rx_phase_reg;
    rx_bit_next = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    rx_match_next = rx_match_reg;
    rx_err_next = rx_err_reg;
    rx_line_prev_next = rx_line_prev_reg;
    if (tick) begin
      rx_phase_next = rx_phase_reg + 4'h1;
      rx_line_prev_next = rx_line;
      unique case (rx_state_reg)
        RX_IDLE: begin
          // a line still low from a broken stop bit is no start bit
          if (rx_line_prev_reg && !rx_line) begin
            rx_state_next = RX_START;
            rx_phase_next = 4'h1;
          end
        end
        RX_START: begin
          if (rx_phase_reg == 4'(`SAMPLES_PER_BIT / 2 - 1)) begin
            if (rx_line) begin
              rx_state_next = RX_IDLE;
            end else begin
              rx_state_next = RX_DATA;
              rx_phase_next = 4'h0;
              rx_bit_next = 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (rx_phase_reg == 4'(`SAMPLES_PER_BIT - 1)) begin
            rx_shift_next = {rx_line, rx_shift_reg[8:1]};
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h8) begin
              rx_state_next = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_phase_reg == 4'(`SAMPLES_PER_BIT - 1)) begin
            rx_state_next = RX_IDLE;
            rx_data_next = rx_shift_reg[7:0];
            rx_valid_next = 1'b1;
            rx_err_next = !rx_line;
            rx_match_next = rx_shift_reg[8] && (rx_shift_reg[7:0] == addr_match_reg);
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rx_state_reg <= RX_IDLE;
      rx_phase_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_match_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      rx_line_prev_reg <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_phase_reg <= rx_phase_next;
      rx_bit_reg <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
      rx_match_reg <= rx_match_next;
      rx_err_reg <= rx_err_next;
      rx_line_prev_reg <= rx_line_prev_next;
    end
  end

  assign rx_data_o = rx_data_reg;
  assign rx_valid_o = rx_valid_reg;
  assign rx_addr_match_o = rx_match_reg;
  assign rx_frame_err_o = rx_err_reg;

  // ---------------- register port
  always_comb begin
    addr_match_next = addr_match_reg;
    div_high_next = div_high_reg;
    div_low_next = div_low_reg;
    ctrl_next = ctrl_reg;
    rdata_next = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        `ADDR_MATCH_OFS: addr_match_next = wdata_i;
        `DIV_HIGH_OFS: div_high_next = wdata_i;
        `DIV_LOW_OFS: div_low_next = wdata_i;
        `CTRL_OFS: ctrl_next = {7'h00, wdata_i[`CTRL_IR_EN_BIT]};
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `ADDR_MATCH_OFS: rdata_next = addr_match_reg;
        `DIV_HIGH_OFS: rdata_next = div_high_reg;
        `DIV_LOW_OFS: rdata_next = div_low_reg;
        `CTRL_OFS: rdata_next = ctrl_reg;
        `STATUS_OFS: rdata_next = {4'h0, rx_match_reg, rx_err_reg,
                                   ir_state_reg == IR_TRACK, rx_state_reg != RX_IDLE};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      addr_match_reg <= `ADDR_MATCH_RST;
      div_high_reg <= `DIV_HIGH_RST;
      div_low_reg <= `DIV_LOW_RST;
      ctrl_reg <= `CTRL_RST;
      rdata_reg <= 8'h00;
    end else begin
      addr_match_reg <= addr_match_next;
      div_high_reg <= div_high_next;
      div_low_reg <= div_low_next;
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_o = rdata_reg;

  // ---------------- checks
  sequence s_fall_in_window;
    ir_state_reg == IR_TRACK && ir_fall && ir_cnt_reg >= 5'(`SAMPLES_PER_BIT - `IR_WINDOW_HALF);
  endsequence
  sequence s_pulse_out;
    !ir_out_reg;
  endsequence

  chk_divisor_concat: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == `DIV_HIGH_OFS |=> baud_divisor[15:8] == $past(wdata_i))
    else $error("divisor high byte misplaced");
  chk_divisor_low: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == `DIV_LOW_OFS |=> baud_divisor[7:0] == $past(wdata_i))
    else $error("divisor low byte misplaced");
  chk_addr_compare: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(rx_valid_reg) |-> rx_match_reg == (rx_shift_reg[8] && rx_data_reg == addr_match_reg))
    else $error("address compare wrong");
  chk_window_pulse: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_fall_in_window and infrared_codec_enable |=> s_pulse_out)
    else $error("in-window pulse lost");
  chk_window_timeout: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ir_state_reg == IR_TRACK && tick && !ir_fall && ir_cnt_reg >= 5'(`SAMPLES_PER_BIT + `IR_WINDOW_HALF)
    |=> ir_state_reg == IR_IDLE) else $error("decoder did not go idle");
  chk_idle_wakeup: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    infrared_codec_enable && ir_state_reg == IR_IDLE && ir_fall |=> ir_state_reg == IR_TRACK && !ir_out_reg)
    else $error("decoder missed falling edge");
  chk_fall_realign: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    infrared_codec_enable && ir_fall |=> ir_cnt_reg == 5'h00)
    else $error("counter not cleared on edge");
  chk_rx_untouched: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !tick |=> $stable(rx_state_reg) && $stable(rx_phase_reg))
    else $error("receiver moved without tick");
  chk_start_align: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    rx_state_reg == RX_IDLE && tick && rx_line_prev_reg && !rx_line |=> rx_state_reg == RX_START && rx_phase_reg == 4'h1)
    else $error("start bit not aligned");
  chk_no_held_start: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    rx_state_reg == RX_IDLE && tick && !rx_line_prev_reg |=> rx_state_reg == RX_IDLE)
    else $error("receiver started without a falling edge");
  chk_ctrl_enable: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == `CTRL_OFS |=> infrared_codec_enable == $past(wdata_i[`CTRL_IR_EN_BIT]))
    else $error("codec enable not written");
  chk_rdata_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
endmodule // uart_baud_and_infrared_codec
`default_nettype wire

// ==== tb/uart_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_far_end (
  input wire logic clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // one bit time; in ir mode a zero is a short low pulse at the bit start
  task automatic put_bit(input logic b, input logic ir, input int div);
    for (int i = 0; i < 16 * div; i++) begin
      @(posedge clk_i);
      line_o <= ir ? !(!b && i < 3 * div) : b;
    end
  endtask
  task automatic send(input logic [8:0] bits, input logic stop_ok, input logic ir, input int div);
    put_bit(1'b0, ir, div);
    for (int k = 0; k < 9; k++) begin
      put_bit(bits[k], ir, div);
    end
    put_bit(stop_ok, ir, div);
    put_bit(1'b1, ir, div);
  endtask
  // too short to pass the mid start-bit check
  task automatic glitch(input int div);
    repeat (2 * div) @(posedge clk_i) line_o <= 1'b0;
    put_bit(1'b1, 1'b0, div);
    put_bit(1'b1, 1'b0, div);
  endtask
endmodule // uart_far_end
`default_nettype wire

// ==== tb/test_uart_baud_and_infrared_codec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "uart_codec_defines.svh"
module test_uart_baud_and_infrared_codec
  import uart_codec_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic tick;
  logic [7:0] rx_data;
  logic rx_valid;
  logic match;
  logic ferr;
  wire logic line;
  int bad_count = 0;
  int check_count = 0;
  int seed = 32'h02c34a63;
  int n;
  logic [15:0] exp_q[$];
  logic [7:0] match_val;
  logic [15:0] last_exp;

  always #2.5 clk = ~clk;

  uart_baud_and_infrared_codec u_dut (
    .ref_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .rx_pin_i(line), .sample_tick_o(tick), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_addr_match_o(match), .rx_frame_err_o(ferr)
  );
  uart_far_end u_far (.clk_i(clk), .line_o(line));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(16'(rdata), 16'(e));
  endtask

  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (tick !== 1'b1 && c < 70000);
  endtask

  task automatic frame(input logic ir, input int div);
    logic [8:0] b;
    logic ok;
    b = 9'($random(seed));
    if ($random(seed) & 1) b[7:0] = match_val;
    ok = ($random(seed) & 3) != 0;
    exp_q.push_back(16'({!ok, b[8] && b[7:0] == match_val, b[7:0]}));
    last_exp = exp_q[$];
    u_far.send(b, ok, ir, div);
  endtask

  // result side: every finished frame takes the oldest note
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check(16'({ferr, match, rx_data}), exp_q.pop_front());
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_chk(`ADDR_MATCH_OFS, `ADDR_MATCH_RST);
    reg_chk(`DIV_HIGH_OFS, `DIV_HIGH_RST);
    reg_chk(`DIV_LOW_OFS, `DIV_LOW_RST);
    match_val = 8'($random(seed));
    reg_wr(`ADDR_MATCH_OFS, match_val);
    reg_wr(12'h000, 8'h5a);
    reg_chk(`ADDR_MATCH_OFS, match_val);
    reg_chk(12'h000, 8'h00);
    for (int d = 2; d <= 3; d++) begin
      reg_wr(`DIV_HIGH_OFS, 8'h00);
      reg_wr(`DIV_LOW_OFS, 8'(d));
      reg_chk(`DIV_LOW_OFS, 8'(d));
      wait_tick(n);
      wait_tick(n);
      check(16'(n), 16'(d));
      reg_wr(`CTRL_OFS, 8'h00);
      u_far.glitch(d);
      repeat (3) frame(1'b0, d);
      // codec enabled before any pulse traffic reaches the pin
      reg_wr(`CTRL_OFS, 8'h01);
      reg_chk(`CTRL_OFS, 8'h01);
      repeat (3) frame(1'b1, d);
    end
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge clk);
    check(16'(exp_q.size()), 16'h0000);
    // status after the decoder window has run out: only the last frame's flags remain
    repeat (200) @(posedge clk);
    reg_chk(`STATUS_OFS, {4'h0, last_exp[8], last_exp[9], 2'b00});
    finish_test;
  end

  // reset-value divisor needs up to 65535 clocks before the first reload
  initial begin
    #500000;
    bad_count++;
    finish_test;
  end
endmodule // test_uart_baud_and_infrared_codec
`default_nettype wire
